//--- rtl/pmc_pkg.sv
// Package with the constants and mode type of the power mode controller.
`default_nettype none
package pmc_pkg;
  // Operating modes of the controller.
  typedef enum logic [1:0] {
    PMC_ACTIVE,
    PMC_STANDBY,
    PMC_SLEEP,
    PMC_RESET
  } pmc_mode_e;
  // System clock rate in Hz.
  localparam int unsigned CLK_HZ            = 50_000_000;
  // Least high time on the reset terminal that wakes from sleep, in ns.
  localparam int unsigned WAKE_PULSE_NS     = 10_000;
  // Wake pulse as a cycle count, rounded up.
  localparam int unsigned WAKE_PULSE_CYC    = (WAKE_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // CPU reset hold interval in system clocks.
  localparam int unsigned CPU_HOLD_CYC      = 32768;
  // Counter widths.
  localparam int unsigned HOLD_W            = 16;
  localparam int unsigned WAKE_W            = 10;
  // Width of port A and of the combination select masks.
  localparam int unsigned PORT_W            = 4;
  // Reset value of the sleep write permit latch.
  localparam logic        PERMIT_RST        = 1'h0;
  // Reset value of a counter.
  localparam logic [HOLD_W-1:0] HOLD_ZERO   = 16'h0000;
  localparam logic [WAKE_W-1:0] WAKE_ZERO   = 10'h000;
endpackage : pmc_pkg
`default_nettype wire

//--- rtl/pmc_port_a_match.sv
// Port A reset combination matcher, one select pair per bit.
`default_nettype none
module pmc_port_a_match (
  // Port A pins and the two select masks.
  input  wire logic [pmc_pkg::PORT_W-1:0] inputPortA,
  input  wire logic [pmc_pkg::PORT_W-1:0] comboSelOne,
  input  wire logic [pmc_pkg::PORT_W-1:0] comboSelTwo,
  // High when every bit term is true.
  output logic                            comboHit
);
  // Per-bit term: 00 never, 01 pin, 10 inverted pin, 11 don't care.
  logic [pmc_pkg::PORT_W-1:0] term;

  genvar i;
  generate
    for (i = 0; i < pmc_pkg::PORT_W; i++) begin : g_bit
      // Each bit picks its term from its select pair.
      assign term[i] = comboSelOne[i] ? (comboSelTwo[i] | ~inputPortA[i])
                                      : (comboSelTwo[i] & inputPortA[i]);
    end
  endgenerate

  // All terms are ANDed together.
  assign comboHit = &term;
endmodule : pmc_port_a_match
`default_nettype wire

//--- rtl/pmc_counter.sv
// Up counter with clear that reports when a terminal count is reached.
`default_nettype none
module pmc_counter #(
  parameter int unsigned W      = 16,
  parameter int unsigned TARGET = 4
) (
  // Clock and synchronous reset.
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Count while high, clear while low.
  input  wire logic run,
  // High once the count has reached TARGET.
  output logic      done
);
  // Running count; saturates at TARGET.
  logic [W-1:0] count;

  // Counter holds at the target so done stays up until run drops.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !run) begin
      count <= '0;
    end else if (count != W'(TARGET)) begin
      count <= count + W'(1);
    end
  end

  // Done reaches the target count.
  assign done = (count == W'(TARGET));
endmodule : pmc_counter
`default_nettype wire

//--- rtl/pmc_power_mode_controller.sv
// Operating mode controller: active, standby, sleep and reset hold.
`default_nettype none
module pmc_power_mode_controller (
  // Clock and power-on reset.
  input  wire logic                            sys_clk,
  input  wire logic                            rst_n,
  // CPU side requests.
  input  wire logic                            haltExec,
  input  wire logic                            sleepWrite,
  input  wire logic                            permitWrite,
  input  wire logic                            permitData,
  input  wire logic                            irqPending,
  // Other reset sources during active and standby.
  input  wire logic                            otherReset,
  // Reset terminal and port A.
  input  wire logic                            resetPin,
  input  wire logic [pmc_pkg::PORT_W-1:0]      inputPortA,
  // Option registers, written by firmware.
  input  wire logic                            optWrite,
  input  wire logic [pmc_pkg::PORT_W-1:0]      optComboSelOne,
  input  wire logic [pmc_pkg::PORT_W-1:0]      optComboSelTwo,
  input  wire logic                            optPortAWake,
  // Voltage level detector measure in progress.
  input  wire logic                            vldBusy,
  // Mode and status.
  output pmc_pkg::pmc_mode_e                   mode,
  output logic                                 sleep_write_permit,
  output logic                                 sleepFlag,
  output logic                                 port_a_wake_reset_option,
  // Clock and reset gates for the rest of the chip.
  output logic                                 cpuClkEn,
  output logic                                 cpuReset,
  output logic                                 sysReset,
  output logic                                 oscEn,
  output logic                                 oscWatchdogEn,
  output logic                                 periphRun,
  output logic                                 vldEn,
  output logic                                 strobeEn,
  // Pin control in sleep.
  output logic                                 portBFloat,
  output logic                                 serialFloat,
  output logic                                 buzzerFloat,
  output logic                                 portAEnable,
  output logic                                 portAPullEn
);
  ////////////////////////////////////////////////////////////////////////////
  // Option registers and combination matcher.
  ////////////////////////////////////////////////////////////////////////////

  // Combination select masks kept across every reset but power-on.
  logic [pmc_pkg::PORT_W-1:0] comboSelOne;
  logic [pmc_pkg::PORT_W-1:0] comboSelTwo;
  // Combination currently present on port A.
  logic                       comboHit;
  // Reset terminal high long enough to wake.
  logic                       wakePulseDone;
  // CPU hold interval complete.
  logic                       holdDone;
  // Voltage detector allowed to run in standby.
  logic                       vldRun;

  // Only power-on reset clears the option registers.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      comboSelOne              <= '0;
      comboSelTwo              <= '0;
      port_a_wake_reset_option <= 1'h0;
    end else if (optWrite) begin
      comboSelOne              <= optComboSelOne;
      comboSelTwo              <= optComboSelTwo;
      port_a_wake_reset_option <= optPortAWake;
    end
  end

  // Matcher for the selected port A combination.
  pmc_port_a_match u_match (
    .inputPortA  (inputPortA),
    .comboSelOne (comboSelOne),
    .comboSelTwo (comboSelTwo),
    .comboHit    (comboHit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Timers.
  ////////////////////////////////////////////////////////////////////////////

  // Reset terminal filter used only to wake from sleep; a short glitch
  // restarts the count, standing in for the analogue filter.
  pmc_counter #(
    .W      (pmc_pkg::WAKE_W),
    .TARGET (pmc_pkg::WAKE_PULSE_CYC)
  ) u_wake (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (resetPin && mode == pmc_pkg::PMC_SLEEP),
    .done    (wakePulseDone)
  );

  // CPU reset hold counter, run in the reset state.
  pmc_counter #(
    .W      (pmc_pkg::HOLD_W + 1),
    .TARGET (pmc_pkg::CPU_HOLD_CYC)
  ) u_hold (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (mode == pmc_pkg::PMC_RESET && !resetPin),
    .done    (holdDone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine.
  ////////////////////////////////////////////////////////////////////////////

  // The mode moves between active, standby, sleep and reset hold.
  // Power-on reset lands in the reset hold so the CPU waits too.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mode <= pmc_pkg::PMC_RESET;
    end else begin
      case (mode)
        pmc_pkg::PMC_ACTIVE: begin
          // Combination or any reset wins over a halt or sleep request.
          if (comboHit || otherReset || resetPin) begin
            mode <= pmc_pkg::PMC_RESET;
          end else if (sleepWrite && sleep_write_permit) begin
            mode <= pmc_pkg::PMC_SLEEP;
          end else if (haltExec) begin
            mode <= pmc_pkg::PMC_STANDBY;
          end
        end
        pmc_pkg::PMC_STANDBY: begin
          // Any reset wins; an enabled interrupt resumes execution.
          if (comboHit || otherReset || resetPin) begin
            mode <= pmc_pkg::PMC_RESET;
          end else if (irqPending) begin
            mode <= pmc_pkg::PMC_ACTIVE;
          end
        end
        pmc_pkg::PMC_SLEEP: begin
          // Only the filtered reset terminal or the enabled combination wakes.
          if (wakePulseDone || (port_a_wake_reset_option && comboHit)) begin
            mode <= pmc_pkg::PMC_RESET;
          end
        end
        pmc_pkg::PMC_RESET: begin
          // Leave only after the full oscillator start-up hold.
          if (holdDone) begin
            mode <= pmc_pkg::PMC_ACTIVE;
          end
        end
        default: begin
          mode <= pmc_pkg::PMC_RESET;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep flag and permit latch.
  ////////////////////////////////////////////////////////////////////////////

  // The permit latch survives every reset but power-on, so firmware can
  // tell a wake from sleep from a fresh power-up.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sleep_write_permit <= pmc_pkg::PERMIT_RST;
    end else if (permitWrite) begin
      sleep_write_permit <= permitData;
    end
  end

  // Sleep flag reads high only while sleeping; the wake clears it.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sleepFlag <= 1'h0;
    end else if (mode == pmc_pkg::PMC_ACTIVE && sleepWrite && sleep_write_permit
                 && !(comboHit || otherReset || resetPin)) begin
      sleepFlag <= 1'h1;
    end else if (mode == pmc_pkg::PMC_SLEEP && (wakePulseDone
                 || (port_a_wake_reset_option && comboHit))) begin
      sleepFlag <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Voltage level detector control.
  ////////////////////////////////////////////////////////////////////////////

  // In standby the detector keeps running only until its measure ends.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vldRun <= 1'h1;
    end else if (mode == pmc_pkg::PMC_ACTIVE) begin
      vldRun <= 1'h1;
    end else if (mode == pmc_pkg::PMC_STANDBY) begin
      vldRun <= vldRun && vldBusy;
    end else begin
      vldRun <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-mode gates.
  ////////////////////////////////////////////////////////////////////////////

  // Instruction clock runs only when active; standby freezes CPU state.
  assign cpuClkEn      = (mode == pmc_pkg::PMC_ACTIVE);
  // Reset is held through sleep and the start-up hold.
  assign cpuReset      = (mode == pmc_pkg::PMC_RESET) || (mode == pmc_pkg::PMC_SLEEP);
  // System reset clears timers, counters, logic watchdog and flags.
  assign sysReset      = cpuReset;
  // Oscillator stops only in sleep.
  assign oscEn         = (mode != pmc_pkg::PMC_SLEEP);
  // Oscillator watchdog is inhibited in sleep and during start-up.
  assign oscWatchdogEn = (mode == pmc_pkg::PMC_ACTIVE) || (mode == pmc_pkg::PMC_STANDBY);
  // Display, interrupts, timers keep running in standby.
  assign periphRun     = oscWatchdogEn;
  assign vldEn         = oscWatchdogEn && vldRun;
  // Strobe stays usable in every mode.
  assign strobeEn      = 1'h1;
  // Pins float in sleep; pulls come from the option register elsewhere.
  assign portBFloat    = (mode == pmc_pkg::PMC_SLEEP);
  assign serialFloat   = portBFloat;
  assign buzzerFloat   = portBFloat;
  // Port A stays alive in sleep only for the wake combination.
  assign portAEnable   = !portBFloat || port_a_wake_reset_option;
  assign portAPullEn   = portAEnable;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  ////////////////////////////////////////////////////////////////////////////

  property p_active_exit;
    @(posedge sys_clk) disable iff (!rst_n)
    (mode == pmc_pkg::PMC_ACTIVE && !comboHit && !otherReset && !resetPin && !haltExec && !sleepWrite)
      |=> mode == pmc_pkg::PMC_ACTIVE;
  endproperty
  a_active_exit: assert property (p_active_exit) else $error("Active left without cause.");

  property p_halt;
    @(posedge sys_clk) disable iff (!rst_n)
    (mode == pmc_pkg::PMC_ACTIVE && haltExec && !sleepWrite && !comboHit && !otherReset && !resetPin)
      |=> !cpuClkEn && periphRun && oscEn;
  endproperty
  a_halt: assert property (p_halt) else $error("Halt did not stop only the CPU.");

  property p_standby_exit;
    @(posedge sys_clk) disable iff (!rst_n)
    (mode == pmc_pkg::PMC_STANDBY && irqPending && !comboHit && !otherReset && !resetPin)
      |=> cpuClkEn;
  endproperty
  a_standby_exit: assert property (p_standby_exit) else $error("Interrupt did not end standby.");

  property p_permit;
    @(posedge sys_clk) disable iff (!rst_n)
    (mode == pmc_pkg::PMC_ACTIVE && sleepWrite && !sleep_write_permit && !haltExec)
      |=> mode != pmc_pkg::PMC_SLEEP;
  endproperty
  a_permit: assert property (p_permit) else $error("Sleep entered without permit.");

  property p_sleep_gates;
    @(posedge sys_clk) disable iff (!rst_n)
    mode == pmc_pkg::PMC_SLEEP |-> !oscEn && cpuReset && portBFloat && buzzerFloat && !vldEn;
  endproperty
  a_sleep_gates: assert property (p_sleep_gates) else $error("Sleep gates wrong.");

  property p_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(mode == pmc_pkg::PMC_RESET) |-> cpuReset [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("Reset hold too short.");

  // Cycles spent in the reset hold with the reset terminal low.
  // The hold counter saturates and hides its value, so a plain count here
  // lets the check see the real length of the hold on its way out.
  logic [pmc_pkg::HOLD_W:0] holdCycles;

  // Helper count for the hold length check; it restarts as the hold does.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || mode != pmc_pkg::PMC_RESET || resetPin) begin
      holdCycles <= '0;
    end else begin
      holdCycles <= holdCycles + (pmc_pkg::HOLD_W + 1)'(1);
    end
  end

  property p_hold_len;
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(mode == pmc_pkg::PMC_RESET) |-> holdCycles >= pmc_pkg::CPU_HOLD_CYC;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("Reset hold ended before start-up time.");

  property p_wake_keeps_permit;
    @(posedge sys_clk) disable iff (!rst_n)
    (mode == pmc_pkg::PMC_SLEEP && !permitWrite) ##1 (mode == pmc_pkg::PMC_RESET)
      |-> sleep_write_permit == $past(sleep_write_permit) && !sleepFlag;
  endproperty
  a_wake_keeps_permit: assert property (p_wake_keeps_permit) else $error("Wake changed permit.");

  property p_port_a;
    @(posedge sys_clk) disable iff (!rst_n)
    (mode == pmc_pkg::PMC_SLEEP && !port_a_wake_reset_option) |-> !portAEnable && !portAPullEn;
  endproperty
  a_port_a: assert property (p_port_a) else $error("Port A active in sleep.");
endmodule : pmc_power_mode_controller
`default_nettype wire

//--- tb/tb.sv
// Self-checking testbench of the power mode controller, driven through its plain ports.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////////////
  // Design stimulus and observed outputs.
  logic                        sys_clk = 1'h0;       // System clock, 50 MHz.
  logic                        rst_n = 1'h0;         // Power-on reset, active low.
  logic                        haltExec = 1'h0;      // Halt instruction pulse.
  logic                        sleepWrite = 1'h0;    // Sleep request write pulse.
  logic                        permitWrite = 1'h0;   // Permit bit write pulse.
  logic                        permitData = 1'h0;    // Permit bit write data.
  logic                        irqPending = 1'h0;    // Enabled interrupt request.
  logic                        otherReset = 1'h0;    // Watchdog style reset source.
  logic                        resetPin = 1'h0;      // Reset terminal.
  logic [pmc_pkg::PORT_W-1:0]  inputPortA = 4'h0;    // Port A pins.
  logic                        optWrite = 1'h0;      // Option write pulse.
  logic [pmc_pkg::PORT_W-1:0]  optComboSelOne = 4'h0; // First combination mask.
  logic [pmc_pkg::PORT_W-1:0]  optComboSelTwo = 4'h0; // Second combination mask.
  logic                        optPortAWake = 1'h0;  // Port A wake option.
  logic                        vldBusy = 1'h0;       // Level detector measuring.
  pmc_pkg::pmc_mode_e          mode;                 // Present mode.
  logic sleep_write_permit, sleepFlag, port_a_wake_reset_option;
  logic cpuClkEn, cpuReset, sysReset, oscEn, oscWatchdogEn, periphRun, vldEn, strobeEn;
  logic portBFloat, serialFloat, buzzerFloat, portAEnable, portAPullEn;
  logic [9:0]                  gates;                // Mode gates packed for one compare.
  int                          failCount = 0;        // Mismatches seen.
  int                          cmpCount = 0;         // Comparisons made.
  int                          n;                    // Cycles waited.
  // Expected gate patterns per mode.
  localparam logic [9:0] G_ACT = 10'h278;
  localparam logic [9:0] G_STB = 10'h078;
  localparam logic [9:0] G_SLP = 10'h18f;
  assign gates = {cpuClkEn, cpuReset, sysReset, oscEn, oscWatchdogEn, periphRun,
                  strobeEn, portBFloat, serialFloat, buzzerFloat};
  ////////////////////////////////////////////////////////////////////////////////
  // Clock toggles every half period.
  always #10 sys_clk = ~sys_clk;
  // Device under test.
  pmc_power_mode_controller dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .haltExec(haltExec), .sleepWrite(sleepWrite),
    .permitWrite(permitWrite), .permitData(permitData), .irqPending(irqPending),
    .otherReset(otherReset), .resetPin(resetPin), .inputPortA(inputPortA), .optWrite(optWrite),
    .optComboSelOne(optComboSelOne), .optComboSelTwo(optComboSelTwo), .optPortAWake(optPortAWake),
    .vldBusy(vldBusy), .mode(mode), .sleep_write_permit(sleep_write_permit), .sleepFlag(sleepFlag),
    .port_a_wake_reset_option(port_a_wake_reset_option), .cpuClkEn(cpuClkEn), .cpuReset(cpuReset),
    .sysReset(sysReset), .oscEn(oscEn), .oscWatchdogEn(oscWatchdogEn), .periphRun(periphRun),
    .vldEn(vldEn), .strobeEn(strobeEn), .portBFloat(portBFloat), .serialFloat(serialFloat),
    .buzzerFloat(buzzerFloat), .portAEnable(portAEnable), .portAPullEn(portAPullEn));
  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value; four-state equality so an unknown never matches.
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmpCount++;
    if (got !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Lets a number of cycles pass, ending just after a falling edge.
  task automatic idle(input int c);
    repeat (c) @(negedge sys_clk);
  endtask : idle
  // Raises a one-cycle pulse; the mode is settled when the task returns.
  task automatic pulse(ref logic s);
    s = 1'h1;
    @(negedge sys_clk);
    s = 1'h0;
  endtask : pulse
  // Waits for a mode under a bound; a miss counts as a mismatch.
  task automatic waitMode(input pmc_pkg::pmc_mode_e m, input int lim, output int c);
    c = 0;
    while (mode !== m && c < lim) begin
      @(negedge sys_clk);
      c++;
    end
    chk("mode reached", 16'(m), 16'(mode));
  endtask : waitMode
  // Writes the option registers together.
  task automatic setOpt(input logic [3:0] one, input logic [3:0] two, input logic wake);
    optComboSelOne = one;
    optComboSelTwo = two;
    optPortAWake = wake;
    pulse(optWrite);
  endtask : setOpt
  // Prints the verdict and ends the run.
  task automatic results();
    if (failCount == 0 && cmpCount > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: the run needs about 67000 cycles.
  initial begin
    #(90000 * 20);
    failCount++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main test sequence.
  initial begin
    idle(10);
    chk("mode in por", 16'(pmc_pkg::PMC_RESET), 16'(mode));
    chk("permit after por", 16'h0000, 16'(sleep_write_permit));
    rst_n = 1'h1;
    chk("cpuReset in hold", 16'h0001, 16'(cpuReset));
    waitMode(pmc_pkg::PMC_ACTIVE, 33000, n);
    chk("hold length ok", 16'h0001, 16'(n >= 32760 && n <= 32775));
    chk("active gates", 16'(G_ACT), 16'(gates));
    // Sleep write with the permit clear is refused.
    pulse(sleepWrite);
    idle(2);
    chk("refused sleep", 16'(pmc_pkg::PMC_ACTIVE), 16'(mode));
    chk("no sleep flag", 16'h0000, 16'(sleepFlag));
    // Halt enters standby; detector finishes its measure then stops.
    vldBusy = 1'h1;
    pulse(haltExec);
    chk("standby", 16'(pmc_pkg::PMC_STANDBY), 16'(mode));
    chk("standby gates", 16'(G_STB), 16'(gates));
    chk("vld busy runs", 16'h0001, 16'(vldEn));
    vldBusy = 1'h0;
    idle(2);
    chk("vld stopped", 16'h0000, 16'(vldEn));
    // Permit, then a sleep write while halted is ignored.
    permitData = 1'h1;
    pulse(permitWrite);
    chk("permit set", 16'h0001, 16'(sleep_write_permit));
    pulse(sleepWrite);
    idle(2);
    chk("sleep in standby", 16'(pmc_pkg::PMC_STANDBY), 16'(mode));
    irqPending = 1'h1;
    idle(2);
    chk("irq wakes", 16'(pmc_pkg::PMC_ACTIVE), 16'(mode));
    irqPending = 1'h0;
    // Port A bit 0 low with bit 1 high is the wake combination, sleep wake option on.
    setOpt(4'hd, 4'he, 1'h1);
    chk("wake option", 16'h0001, 16'(port_a_wake_reset_option));
    // Sleep and halt in one cycle: sleep wins.
    haltExec = 1'h1;
    pulse(sleepWrite);
    haltExec = 1'h0;
    chk("sleep entry", 16'(pmc_pkg::PMC_SLEEP), 16'(mode));
    chk("sleep flag", 16'h0001, 16'(sleepFlag));
    chk("sleep gates", 16'(G_SLP), 16'(gates));
    vldBusy = 1'h1;
    idle(2);
    chk("vld off asleep", 16'h0000, 16'(vldEn));
    vldBusy = 1'h0;
    chk("port A kept", 16'h0001, 16'(portAEnable));
    chk("pull kept", 16'h0001, 16'(portAPullEn));
    // A reset pulse shorter than the filter leaves sleep alone.
    resetPin = 1'h1;
    idle(490);
    resetPin = 1'h0;
    idle(5);
    chk("short pin", 16'(pmc_pkg::PMC_SLEEP), 16'(mode));
    // Bit 0 high breaks the inverted term, so a half match leaves sleep alone.
    inputPortA = 4'h3;
    idle(3);
    chk("half combo", 16'(pmc_pkg::PMC_SLEEP), 16'(mode));
    // The combination wakes at once, flag cleared, permit kept.
    inputPortA = 4'h2;
    waitMode(pmc_pkg::PMC_RESET, 3, n);
    inputPortA = 4'h0;
    chk("flag cleared", 16'h0000, 16'(sleepFlag));
    chk("permit kept", 16'h0001, 16'(sleep_write_permit));
    chk("cpu held", 16'h0001, 16'(cpuReset));
    idle(32000);
    chk("still held", 16'(pmc_pkg::PMC_RESET), 16'(mode));
    waitMode(pmc_pkg::PMC_ACTIVE, 1000, n);
    chk("options kept", 16'h0001, 16'(port_a_wake_reset_option));
    // Sleep again with the port A option off: only the pin wakes.
    setOpt(4'hd, 4'he, 1'h0);
    pulse(sleepWrite);
    chk("sleep again", 16'(pmc_pkg::PMC_SLEEP), 16'(mode));
    chk("port A off", 16'h0000, 16'(portAEnable));
    chk("pull off", 16'h0000, 16'(portAPullEn));
    inputPortA = 4'h2;
    idle(5);
    chk("combo ignored", 16'(pmc_pkg::PMC_SLEEP), 16'(mode));
    // Other reset sources are dead in sleep and never touch the latches.
    otherReset = 1'h1;
    idle(3);
    otherReset = 1'h0;
    chk("other reset ignored", 16'(pmc_pkg::PMC_SLEEP), 16'(mode));
    chk("permit survives", 16'h0001, 16'(sleep_write_permit));
    inputPortA = 4'h0;
    resetPin = 1'h1;
    idle(505);
    waitMode(pmc_pkg::PMC_RESET, 10, n);
    resetPin = 1'h0;
    // Power-on reset alone clears the permit and the options.
    rst_n = 1'h0;
    idle(2);
    chk("por permit", 16'h0000, 16'(sleep_write_permit));
    chk("por option", 16'h0000, 16'(port_a_wake_reset_option));
    results();
  end
endmodule : tb
`default_nettype wire
